// ---- obc_option_decoder.v ----
// option byte loader and decoder with its AXI4-Lite status port
// Function
// - watchdog run bit set starts the counter at reset release, else it stays stopped.
// - window field 01, 10, 11 give 50, 75, 100 percent; 00 is prohibited.
// - interval interrupt bit enables an interrupt at 75 percent plus half a period.
// - detector byte: group bits 7-5, fixed one at 4, level 3-2, mode 1-0.
// - mode 10 is combined mode: group sets lower, level sets one upper threshold.
// - reset-only mode maps group and level to one of fourteen thresholds.
// - interrupt-only mode uses the same fourteen-entry encoding as reset mode.
// - detector off when mode bit 0 and top group bit are both one.
// - flash mode 00 low-voltage, 10 low-speed, 11 high-speed; 01 prohibited.
// - frequency field maps seven codes to 32 down to 1 MHz; bits 5-4 fixed 10.
// - debug bits 7,0: 00 off, 01 prohibited, 10 erase on failure, 11 keep.
// - bytes are read and applied at every reset release before the program runs.
// - overflow field selects 2^6 up to 2^16 slow oscillator periods.
// - standby bit keeps the watchdog counting in halt and stop modes.
`timescale 1ns/10ps
`include "obc_defs.vh"

module obc_option_decoder
(
  input  wire        clock,
  input  wire        resetn,
  // option byte storage
  input  wire        bootSwapStrap,
  output wire        optRdReq,
  output reg  [16:0] optRdAddr_ff,
  input  wire        optRdAck,
  input  wire [7:0]  optRdData,
  // configuration outputs
  output reg         cfgValid_ff,
  output reg         wdRunAfterReset_ff,
  output reg  [6:0]  wdWindowPct_ff,
  output reg         wdIntervalIrqEn_ff,
  output reg  [16:0] wdOverflowPeriods_ff,
  output reg  [17:0] wdIntervalHalfPeriods_ff,
  output reg         wdCountInStandby_ff,
  output reg  [3:0]  lvModeOneHot_ff,
  output reg  [3:0]  lvLevelIdx_ff,
  output reg  [1:0]  lvLowerIdx_ff,
  output reg  [1:0]  lvUpperIdx_ff,
  output reg  [2:0]  flashModeOneHot_ff,
  output reg  [5:0]  oscFreqMhz_ff,
  output reg         debugEnable_ff,
  output reg         debugEraseOnFail_ff,
  output reg         cfgError_ff,
  output wire        irqOut,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // --------------------------------------------------------------------
  // loader state machine
  // --------------------------------------------------------------------
  localparam ST_CAPTURE = 4'b0001;
  localparam ST_FETCH   = 4'b0010;
  localparam ST_APPLY   = 4'b0100;
  localparam ST_DONE    = 4'b1000;

  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [1:0]  byteIdx_ff;
  reg  [1:0]  nxt_byteIdx;
  reg         mirror_ff;
  reg  [7:0]  optByte_ff [0:3];
  wire [16:0] optBase;

  // the swap only exchanges contents, so either bank decodes alike
  assign optBase  = mirror_ff ? `OBC_OPT_BASE_MIR : `OBC_OPT_BASE_PRI;
  assign optRdReq = state_ff[1];

  always @*
  begin
    nxt_state   = state_ff;
    nxt_byteIdx = byteIdx_ff;
    case (state_ff)
      ST_CAPTURE:
      begin
        nxt_state   = ST_FETCH;
        nxt_byteIdx = 2'h0;
      end
      ST_FETCH:
      begin
        if (optRdAck)
        begin
          nxt_byteIdx = byteIdx_ff + 2'h1;
          if (byteIdx_ff == `OBC_IDX_LAST)
          begin
            nxt_state = ST_APPLY;
          end
        end
      end
      ST_APPLY:
      begin
        nxt_state = ST_DONE;
      end
      ST_DONE:
      begin
        // nothing reloads until the next reset; software has no path here
        nxt_state = ST_DONE;
      end
      default:
      begin
        nxt_state = ST_CAPTURE;
      end
    endcase
  end

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff     <= ST_CAPTURE;
      byteIdx_ff   <= 2'h0;
      mirror_ff    <= 1'b0;
      optRdAddr_ff <= `OBC_OPT_BASE_PRI;
    end
    else
    begin
      state_ff   <= nxt_state;
      byteIdx_ff <= nxt_byteIdx;
      if (state_ff[0])
      begin
        // strap caught on the first edge after release
        mirror_ff    <= bootSwapStrap;
        optRdAddr_ff <= bootSwapStrap ? `OBC_OPT_BASE_MIR : `OBC_OPT_BASE_PRI;
      end
      else
      begin
        optRdAddr_ff <= optBase + {15'h0000, nxt_byteIdx};
      end
    end
  end

  // --------------------------------------------------------------------
  // option byte storage
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_byte
      always @(posedge clock or negedge resetn)
      begin
        if (!resetn)
        begin
          optByte_ff[gi] <= 8'h00;
        end
        else if (state_ff[1] && optRdAck && (byteIdx_ff == gi))
        begin
          optByte_ff[gi] <= optRdData;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------------
  wire [7:0] wdByte  = optByte_ff[`OBC_IDX_WD];
  wire [7:0] lvByte  = optByte_ff[`OBC_IDX_LV];
  wire [7:0] oscByte = optByte_ff[`OBC_IDX_OSC];
  wire [7:0] dbgByte = optByte_ff[`OBC_IDX_DBG];

  wire [3:0] nxt_lvModeOneHot;
  wire [3:0] nxt_lvLevelIdx;
  wire [1:0] nxt_lvLowerIdx;
  wire [1:0] nxt_lvUpperIdx;
  wire       lvProhibited;

  obc_lvd_decode u_lvd
  (
    .lvByte       (lvByte),
    .lvModeOneHot (nxt_lvModeOneHot),
    .lvLevelIdx   (nxt_lvLevelIdx),
    .lvLowerIdx   (nxt_lvLowerIdx),
    .lvUpperIdx   (nxt_lvUpperIdx),
    .lvProhibited (lvProhibited)
  );

  reg  [6:0]  nxt_wdWindowPct;
  reg  [4:0]  ovfExp;
  reg  [2:0]  nxt_flashMode;
  reg  [5:0]  nxt_oscFreqMhz;
  reg  [5:0]  mhzCeiling;
  reg  [4:0]  nxt_errSrc;
  wire [16:0] nxt_wdOverflow;
  wire [16:0] intervalPeriods;

  // the half period is added on apply, as the low one bit of a half-period count
  assign nxt_wdOverflow  = 17'h00001 << ovfExp;
  assign intervalPeriods = (nxt_wdOverflow >> 2) + (nxt_wdOverflow >> 1);

  always @*
  begin
    nxt_errSrc = 5'h00;
    case (wdByte[`OBC_WD_WIN_HI:`OBC_WD_WIN_LO])
      `OBC_WIN_50:  nxt_wdWindowPct = `OBC_PCT_50;
      `OBC_WIN_75:  nxt_wdWindowPct = `OBC_PCT_75;
      `OBC_WIN_100: nxt_wdWindowPct = `OBC_PCT_100;
      default:
      begin
        nxt_wdWindowPct = 7'h00;
        nxt_errSrc[`OBC_IDX_WD] = 1'b1;
      end
    endcase
    case (wdByte[`OBC_WD_OVF_HI:`OBC_WD_OVF_LO])
      3'h0:    ovfExp = 5'h06;
      3'h1:    ovfExp = 5'h07;
      3'h2:    ovfExp = 5'h08;
      3'h3:    ovfExp = 5'h09;
      3'h4:    ovfExp = 5'h0B;
      3'h5:    ovfExp = 5'h0D;
      3'h6:    ovfExp = 5'h0E;
      default: ovfExp = 5'h10;
    endcase
    nxt_errSrc[`OBC_IDX_LV] = lvProhibited;
    case (oscByte[`OBC_OSC_FM_HI:`OBC_OSC_FM_LO])
      `OBC_FM_LV:
      begin
        nxt_flashMode = 3'b001;
        mhzCeiling    = `OBC_MHZ_CEIL_LV;
      end
      `OBC_FM_LS:
      begin
        nxt_flashMode = 3'b010;
        mhzCeiling    = `OBC_MHZ_CEIL_LS;
      end
      `OBC_FM_HS:
      begin
        nxt_flashMode = 3'b100;
        mhzCeiling    = `OBC_MHZ_CEIL_HS;
      end
      default:
      begin
        nxt_flashMode = 3'b000;
        mhzCeiling    = 6'h00;
        nxt_errSrc[`OBC_IDX_OSC] = 1'b1;
      end
    endcase
    case (oscByte[`OBC_OSC_FRQ_HI:`OBC_OSC_FRQ_LO])
      4'h8:    nxt_oscFreqMhz = 6'h20;
      4'h0:    nxt_oscFreqMhz = 6'h18;
      4'h9:    nxt_oscFreqMhz = 6'h10;
      4'h1:    nxt_oscFreqMhz = 6'h0C;
      4'hA:    nxt_oscFreqMhz = 6'h08;
      4'hB:    nxt_oscFreqMhz = 6'h04;
      4'hD:    nxt_oscFreqMhz = 6'h01;
      default:
      begin
        nxt_oscFreqMhz = 6'h00;
        nxt_errSrc[`OBC_IDX_OSC] = 1'b1;
      end
    endcase
    if (oscByte[`OBC_OSC_FIX_HI:`OBC_OSC_FIX_LO] != `OBC_OSC_FIX_VAL)
    begin
      nxt_errSrc[`OBC_IDX_OSC] = 1'b1;
    end
    // flagged only; the clock generator is not held back by it
    if (nxt_oscFreqMhz > mhzCeiling)
    begin
      nxt_errSrc[4] = 1'b1;
    end
    if ((dbgByte[`OBC_DBG_FIX_HI:`OBC_DBG_FIX_LO] != `OBC_DBG_FIX_VAL) ||
        (!dbgByte[`OBC_DBG_EN] && dbgByte[`OBC_DBG_KEEP]))
    begin
      nxt_errSrc[`OBC_IDX_DBG] = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // configuration outputs, applied once per reset
  // --------------------------------------------------------------------
  reg  [4:0] errSrc_ff;

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      // safe defaults until the bytes are in: watchdog stopped, debug off
      cfgValid_ff              <= 1'b0;
      wdRunAfterReset_ff       <= 1'b0;
      wdWindowPct_ff           <= 7'h00;
      wdIntervalIrqEn_ff       <= 1'b0;
      wdOverflowPeriods_ff     <= 17'h00000;
      wdIntervalHalfPeriods_ff <= 18'h00000;
      wdCountInStandby_ff      <= 1'b0;
      lvModeOneHot_ff          <= 4'h0;
      lvLevelIdx_ff            <= 4'h0;
      lvLowerIdx_ff            <= 2'h0;
      lvUpperIdx_ff            <= 2'h0;
      flashModeOneHot_ff       <= 3'h0;
      oscFreqMhz_ff            <= 6'h00;
      debugEnable_ff           <= 1'b0;
      debugEraseOnFail_ff      <= 1'b0;
      cfgError_ff              <= 1'b0;
      errSrc_ff                <= 5'h00;
    end
    else if (state_ff[2])
    begin
      cfgValid_ff              <= 1'b1;
      wdRunAfterReset_ff       <= wdByte[`OBC_WD_RUN];
      wdWindowPct_ff           <= nxt_wdWindowPct;
      wdIntervalIrqEn_ff       <= wdByte[`OBC_WD_IRQ];
      wdOverflowPeriods_ff     <= nxt_wdOverflow;
      wdIntervalHalfPeriods_ff <= {intervalPeriods, 1'b1};
      wdCountInStandby_ff      <= wdByte[`OBC_WD_STBY];
      lvModeOneHot_ff          <= nxt_lvModeOneHot;
      lvLevelIdx_ff            <= nxt_lvLevelIdx;
      lvLowerIdx_ff            <= nxt_lvLowerIdx;
      lvUpperIdx_ff            <= nxt_lvUpperIdx;
      flashModeOneHot_ff       <= nxt_flashMode;
      oscFreqMhz_ff            <= nxt_oscFreqMhz;
      debugEnable_ff           <= dbgByte[`OBC_DBG_EN];
      debugEraseOnFail_ff      <= dbgByte[`OBC_DBG_EN] & ~dbgByte[`OBC_DBG_KEEP];
      cfgError_ff              <= |nxt_errSrc[3:0];
      errSrc_ff                <= nxt_errSrc;
    end
  end

  // --------------------------------------------------------------------
  // status, mask and interrupt
  // --------------------------------------------------------------------
  reg  [1:0] status_ff;
  reg  [1:0] mask_ff;
  wire [1:0] statusSet;
  wire [1:0] statusClr;
  wire       wrTake;
  wire [7:0] wrAddr;

  assign statusSet = {state_ff[2] & (|nxt_errSrc[3:0]), state_ff[2]};
  assign statusClr = (wrTake && wrAddr == `OBC_OFS_STATUS && s_axi_wstrb[0]) ?
                     s_axi_wdata[1:0] : 2'h0;
  assign irqOut    = |(status_ff & mask_ff);

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      status_ff <= 2'h0;
      mask_ff   <= `OBC_RST_MASK;
    end
    else
    begin
      // a set in the same cycle as its clear wins
      status_ff <= (status_ff & ~statusClr) | statusSet;
      if (wrTake && wrAddr == `OBC_OFS_MASK && s_axi_wstrb[0])
      begin
        mask_ff <= s_axi_wdata[1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------
  reg  [31:0] rdMux;
  reg         rdHit;
  wire        rdTake;
  wire [7:0]  rdAddr;
  wire        wrHit;

  // address and data are taken together in one cycle
  assign wrTake        = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign wrAddr        = {s_axi_awaddr[7:2], 2'b00};
  assign wrHit         = (wrAddr <= `OBC_OFS_ERRSRC);
  assign rdTake        = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rdAddr        = {s_axi_araddr[7:2], 2'b00};

  always @*
  begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case (rdAddr)
      `OBC_OFS_STATUS: rdMux = {30'h00000000, status_ff};
      `OBC_OFS_MASK:   rdMux = {30'h00000000, mask_ff};
      `OBC_OFS_OPT0:   rdMux = {24'h000000, optByte_ff[0]};
      `OBC_OFS_OPT1:   rdMux = {24'h000000, optByte_ff[1]};
      `OBC_OFS_OPT2:   rdMux = {24'h000000, optByte_ff[2]};
      `OBC_OFS_OPT3:   rdMux = {24'h000000, optByte_ff[3]};
      `OBC_OFS_ERRSRC: rdMux = {27'h0000000, errSrc_ff};
      default:         rdHit = 1'b0;
    endcase
  end

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OBC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `OBC_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end
    else
    begin
      if (wrTake)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `OBC_RESP_OKAY : `OBC_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (rdTake)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? `OBC_RESP_OKAY : `OBC_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // obc_option_decoder

// ---- obc_defs.vh ----
// constants of the option byte configuration decoder
`ifndef OBC_DEFS_VH
`define OBC_DEFS_VH

// register offsets (byte addresses)
`define OBC_OFS_STATUS    8'h00
`define OBC_OFS_MASK      8'h04
`define OBC_OFS_OPT0      8'h08
`define OBC_OFS_OPT1      8'h0C
`define OBC_OFS_OPT2      8'h10
`define OBC_OFS_OPT3      8'h14
`define OBC_OFS_ERRSRC    8'h18
`define OBC_RST_MASK      2'h0
`define OBC_RESP_OKAY     2'h0
`define OBC_RESP_SLVERR   2'h2

// status / mask bits
`define OBC_ST_LOADED     0
`define OBC_ST_CFGERR     1

// option byte storage
`define OBC_OPT_BASE_PRI  17'h000C0
`define OBC_OPT_BASE_MIR  17'h010C0
`define OBC_IDX_LAST      2'h3
`define OBC_IDX_WD        0
`define OBC_IDX_LV        1
`define OBC_IDX_OSC       2
`define OBC_IDX_DBG       3

// watchdog byte fields
`define OBC_WD_IRQ        7
`define OBC_WD_WIN_HI     6
`define OBC_WD_WIN_LO     5
`define OBC_WD_RUN        4
`define OBC_WD_OVF_HI     3
`define OBC_WD_OVF_LO     1
`define OBC_WD_STBY       0
`define OBC_WIN_NONE      2'h0
`define OBC_WIN_50        2'h1
`define OBC_WIN_75        2'h2
`define OBC_WIN_100       2'h3
`define OBC_PCT_50        7'h32
`define OBC_PCT_75        7'h4B
`define OBC_PCT_100       7'h64

// low-voltage detector byte fields
`define OBC_LV_GRP_HI     7
`define OBC_LV_GRP_LO     5
`define OBC_LV_FIX        4
`define OBC_LV_LVL_HI     3
`define OBC_LV_LVL_LO     2
`define OBC_LV_MODE_HI    1
`define OBC_LV_MODE_LO    0
`define OBC_LVM_IRQ       2'h1
`define OBC_LVM_COMBO     2'h2
`define OBC_LVM_RESET     2'h3

// oscillator / flash byte fields
`define OBC_OSC_FM_HI     7
`define OBC_OSC_FM_LO     6
`define OBC_OSC_FIX_HI    5
`define OBC_OSC_FIX_LO    4
`define OBC_OSC_FIX_VAL   2'h2
`define OBC_OSC_FRQ_HI    3
`define OBC_OSC_FRQ_LO    0
`define OBC_FM_LV         2'h0
`define OBC_FM_LS         2'h2
`define OBC_FM_HS         2'h3
`define OBC_MHZ_CEIL_LV   6'h04
`define OBC_MHZ_CEIL_LS   6'h08
`define OBC_MHZ_CEIL_HS   6'h20

// debug byte fields
`define OBC_DBG_EN        7
`define OBC_DBG_KEEP      0
`define OBC_DBG_FIX_HI    6
`define OBC_DBG_FIX_LO    1
`define OBC_DBG_FIX_VAL   6'h02

`endif

// ---- obc_lvd_decode.v ----
// low-voltage detector option byte decoder
`timescale 1ns/10ps
`include "obc_defs.vh"

module obc_lvd_decode
(
  input  wire [7:0] lvByte,
  output reg  [3:0] lvModeOneHot,
  output reg  [3:0] lvLevelIdx,
  output reg  [1:0] lvLowerIdx,
  output reg  [1:0] lvUpperIdx,
  output reg        lvProhibited
);

  wire [2:0] grp  = lvByte[`OBC_LV_GRP_HI:`OBC_LV_GRP_LO];
  wire [1:0] lvl  = lvByte[`OBC_LV_LVL_HI:`OBC_LV_LVL_LO];
  wire [1:0] mode = lvByte[`OBC_LV_MODE_HI:`OBC_LV_MODE_LO];

  // modeOneHot: [0] off, [1] reset only, [2] interrupt only, [3] combined
  always @*
  begin
    lvModeOneHot = 4'h0;
    lvLevelIdx   = 4'h0;
    lvLowerIdx   = grp[1:0];
    lvUpperIdx   = 2'h0;
    lvProhibited = 1'b0;
    if (mode[0] && grp[2])
    begin
      lvModeOneHot = 4'h1;
    end
    else if (mode == `OBC_LVM_COMBO)
    begin
      lvModeOneHot = 4'h8;
      lvProhibited = grp[2] | ~lvByte[`OBC_LV_FIX];
      case (lvl)
        2'h2:    lvUpperIdx = 2'h0;
        2'h1:    lvUpperIdx = 2'h1;
        2'h0:    lvUpperIdx = 2'h2;
        default: lvProhibited = 1'b1;
      endcase
    end
    else if (mode[0])
    begin
      // index runs from the lowest threshold upward
      lvModeOneHot = (mode == `OBC_LVM_RESET) ? 4'h2 : 4'h4;
      lvProhibited = ~lvByte[`OBC_LV_FIX];
      case ({grp, lvl})
        5'h03:   lvLevelIdx = 4'h0;
        5'h02:   lvLevelIdx = 4'h1;
        5'h07:   lvLevelIdx = 4'h2;
        5'h06:   lvLevelIdx = 4'h3;
        5'h05:   lvLevelIdx = 4'h4;
        5'h0B:   lvLevelIdx = 4'h5;
        5'h0A:   lvLevelIdx = 4'h6;
        5'h09:   lvLevelIdx = 4'h7;
        5'h0F:   lvLevelIdx = 4'h8;
        5'h0E:   lvLevelIdx = 4'h9;
        5'h0D:   lvLevelIdx = 4'hA;
        5'h04:   lvLevelIdx = 4'hB;
        5'h08:   lvLevelIdx = 4'hC;
        5'h0C:   lvLevelIdx = 4'hD;
        default: lvProhibited = 1'b1;
      endcase
    end
    else
    begin
      lvProhibited = 1'b1;
    end
  end

endmodule // obc_lvd_decode

// ---- obc_flash_model.sv ----
// behavioural option byte storage answering the decoder's fetches
`timescale 1ns/10ps
module obc_flash_model
(
  input  wire        clock,
  input  wire        optRdReq,
  input  wire [16:0] optRdAddr_ff,
  input  wire [31:0] optImage,
  input  wire [1:0]  ackDelay,
  output reg         optRdAck = 1'b0,
  output reg  [7:0]  optRdData = 8'h00
);
  reg  [1:0] waitCnt_ff = 2'h0;
  // both banks hold one image, so a swapped boot reads the same bytes
  wire       inBank = optRdAddr_ff[16:2] == 15'h0030 || optRdAddr_ff[16:2] == 15'h0430;

  // off an answer the data lines toggle, so a stale byte is never reused
  always @(posedge clock)
  begin
    if (optRdAck)
    begin
      // one pulse per byte: the address moves only on the taking edge
      optRdAck <= 1'b0;
      optRdData <= ~optRdData;
      waitCnt_ff <= 2'h0;
    end
    else if (optRdReq && waitCnt_ff == ackDelay && inBank)
    begin
      optRdAck <= 1'b1;
      optRdData <= optImage[8 * optRdAddr_ff[1:0] +: 8];
      waitCnt_ff <= 2'h0;
    end
    else
    begin
      optRdAck <= 1'b0;
      optRdData <= ~optRdData;
      waitCnt_ff <= optRdReq ? waitCnt_ff + 2'h1 : 2'h0;
    end
  end
endmodule // obc_flash_model

// ---- obc_option_decoder_asserts.sv ----
// port checker of the option byte decoder
`timescale 1ns/10ps
module obc_decoder_chk
(
  input wire        clock,
  input wire        resetn,
  input wire        optRdReq,
  input wire [16:0] optRdAddr_ff,
  input wire        optRdAck,
  input wire [7:0]  optRdData,
  input wire        cfgValid_ff,
  input wire        wdRunAfterReset_ff,
  input wire [6:0]  wdWindowPct_ff,
  input wire        wdIntervalIrqEn_ff,
  input wire [16:0] wdOverflowPeriods_ff,
  input wire        wdCountInStandby_ff,
  input wire [3:0]  lvModeOneHot_ff,
  input wire [2:0]  flashModeOneHot_ff,
  input wire        debugEnable_ff,
  input wire        debugEraseOnFail_ff
);
  // no reset needed: checks wait for a complete fresh load
  reg  [7:0] optByte_ff [0:3];
  wire [7:0] wd = optByte_ff[0];
  wire [7:0] lv = optByte_ff[1];
  wire [7:0] os = optByte_ff[2];
  wire [7:0] db = optByte_ff[3];

  always @(posedge clock)
  begin
    if (optRdReq && optRdAck)
      optByte_ff[optRdAddr_ff[1:0]] <= optRdData;
  end

  function automatic int ovfExp(input [2:0] c);
    return (c < 3'h4) ? 6 + c : (c == 3'h4) ? 11 : (c == 3'h5) ? 13 : (c == 3'h6) ? 14 : 16;
  endfunction

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // load and decode
  // ----------------------------------------
  sequence lastTaken;
    optRdReq && optRdAck && optRdAddr_ff[1:0] == 2'h3;
  endsequence
  sequence applied;
    !optRdReq ##[1:2] cfgValid_ff;
  endsequence

  load_done_a: assert property (lastTaken |=> applied)
    else $error("config not applied after last byte");
  cfg_hold_a: assert property (cfgValid_ff |=> cfgValid_ff && !optRdReq)
    else $error("config dropped or refetched");
  run_bit_a: assert property (cfgValid_ff |-> wdRunAfterReset_ff == wd[4])
    else $error("watchdog run bit wrong");
  window_sel_a: assert property (cfgValid_ff |->
    wdWindowPct_ff == ((wd[6:5] == 2'h0) ? 0 : 25 + 25 * wd[6:5]))
    else $error("window percent wrong");
  interval_en_a: assert property (cfgValid_ff |-> wdIntervalIrqEn_ff == wd[7])
    else $error("interval enable wrong");
  overflow_sel_a: assert property (cfgValid_ff |->
    wdOverflowPeriods_ff == (17'h1 << ovfExp(wd[3:1])))
    else $error("overflow periods wrong");
  standby_sel_a: assert property (cfgValid_ff |-> wdCountInStandby_ff == wd[0])
    else $error("standby bit wrong");
  flash_mode_a: assert property (cfgValid_ff |-> flashModeOneHot_ff ==
    ((os[7:6] == 2'h0) ? 3'h1 : (os[7:6] == 2'h2) ? 3'h2 : (os[7:6] == 2'h3) ? 3'h4 : 3'h0))
    else $error("flash mode wrong");
  debug_mode_a: assert property (cfgValid_ff |->
    {debugEnable_ff, debugEraseOnFail_ff} == {db[7], db[7] & ~db[0]})
    else $error("debug mode wrong");
  lv_off_a: assert property (cfgValid_ff && lv[0] && lv[7] |-> lvModeOneHot_ff == 4'h1)
    else $error("detector not off");
endmodule // obc_decoder_chk

bind obc_option_decoder obc_decoder_chk chk_u
(
  .clock, .resetn, .optRdReq, .optRdAddr_ff, .optRdAck, .optRdData, .cfgValid_ff,
  .wdRunAfterReset_ff, .wdWindowPct_ff, .wdIntervalIrqEn_ff, .wdOverflowPeriods_ff,
  .wdCountInStandby_ff, .lvModeOneHot_ff, .flashModeOneHot_ff, .debugEnable_ff,
  .debugEraseOnFail_ff
);

// ---- tb_option_byte_config_decoder.sv ----
// self-checking bench of the option byte decoder
`timescale 1ns/10ps
module tb_option_byte_config_decoder;
  logic        clock, resetn, bootSwapStrap, optRdReq, optRdAck, cfgValid_ff, irqOut;
  logic        wdRunAfterReset_ff, wdIntervalIrqEn_ff, wdCountInStandby_ff, cfgError_ff;
  logic        debugEnable_ff, debugEraseOnFail_ff, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  lvLowerIdx_ff, lvUpperIdx_ff, s_axi_bresp, s_axi_rresp, ackDelay, rsp;
  logic [2:0]  flashModeOneHot_ff;
  logic [3:0]  lvModeOneHot_ff, lvLevelIdx_ff, s_axi_wstrb;
  logic [5:0]  oscFreqMhz_ff;
  logic [6:0]  wdWindowPct_ff;
  logic [7:0]  optRdData, s_axi_awaddr, s_axi_araddr;
  logic [16:0] optRdAddr_ff, wdOverflowPeriods_ff;
  logic [17:0] wdIntervalHalfPeriods_ff;
  logic [31:0] s_axi_wdata, s_axi_rdata, optImage, rdData;
  // example image, then combined, interrupt-only and off detector cases
  logic [31:0] vec [0:7] = '{32'h84E87F6E, 32'h85AA3AB3, 32'h042B7100, 32'h0528E55C,
                             32'h0, 32'h0, 32'h0, 32'h0};
  int          miscompares = 0, testsRun = 0, seed = 32'h56CE, k, n;

  obc_option_decoder dut_u (.*);
  obc_flash_model flash_u (.*);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (e !== g)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input [7:0] a, input [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    {rdData, rsp} = {s_axi_rdata, s_axi_rresp};
  endtask

  task automatic checkAll(input logic [31:0] b);
    logic [7:0] w, l, o, d;
    int ex[8] = '{6, 7, 8, 9, 11, 13, 14, 16};
    int li[16] = '{0, 0, 1, 0, 11, 4, 3, 2, 12, 7, 6, 5, 13, 10, 9, 8};
    int fq[16] = '{24, 12, 0, 0, 0, 0, 0, 0, 32, 16, 8, 4, 0, 1, 0, 0};
    int ovf, fr, fm, lm, el, err, i;
    {d, o, l, w} = b;
    ovf = 1 << ex[w[3:1]];
    fr = fq[o[3:0]];
    fm = (o[7:6] == 2'h0) ? 1 : (o[7:6] == 2'h2) ? 2 : (o[7:6] == 2'h3) ? 4 : 0;
    lm = (l[0] && l[7]) ? 1 : (l[1:0] == 2'h3) ? 2 : (l[1:0] == 2'h1) ? 4 : (l[1:0] == 2'h2) ? 8 : 0;
    el = (lm == 1) ? 0 : (!l[4] || lm == 0) ? 1 :
         (lm == 8) ? (l[7] || l[3:2] == 2'h3) : (l[6:5] == 2'h0 && !l[3]);
    err = w[6:5] == 2'h0 || el || o[7:6] == 2'h1 || o[5:4] != 2'h2 || fr == 0 ||
          d[6:1] != 6'h02 || {d[7], d[0]} == 2'h1;
    chk("window", (w[6:5] == 2'h0) ? 0 : 25 + 25 * w[6:5], wdWindowPct_ff);
    chk("half", ovf * 3 / 2 + 1, wdIntervalHalfPeriods_ff);
    chk("overflow", ovf, wdOverflowPeriods_ff);
    chk("lvmode", lm, lvModeOneHot_ff);
    if ((lm == 2 || lm == 4) && !el)
      chk("lvlevel", li[{l[6:5], l[3:2]}], lvLevelIdx_ff);
    if (lm == 8 && !el)
      chk("lvpair", {l[6:5], 2'h2 - l[3:2]}, {lvLowerIdx_ff, lvUpperIdx_ff});
    chk("flash", fm, flashModeOneHot_ff);
    chk("freq", fr, oscFreqMhz_ff);
    chk("debug", {d[7], d[7] & ~d[0]}, {debugEnable_ff, debugEraseOnFail_ff});
    chk("cfgerr", err, cfgError_ff);
    rd(8'h00);
    chk("status", {err[0], 1'b1}, rdData);
    for (i = 0; i < 4; i++)
    begin
      rd(8'h08 + 8'(4 * i));
      chk("raw", b[8 * i +: 8], rdData);
    end
    if (fm != 0 && fr != 0)
    begin
      rd(8'h18);
      chk("ceiling", fr > ((fm == 1) ? 4 : (fm == 2) ? 8 : 32), rdData[4]);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    summarize();
  end

  initial
  begin
    {resetn, bootSwapStrap, ackDelay, optImage} = 36'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    for (k = 0; k < 8; k++)
    begin
      if (k > 3)
        vec[k] = $random(seed);
      optImage <= vec[k];
      ackDelay <= 2'($random(seed));
      bootSwapStrap <= 1'($random(seed));
      resetn <= 1'b0;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      n = 0;
      while (cfgValid_ff !== 1'b1 && n < 200)
      begin
        @(posedge clock);
        n++;
      end
      chk("loaded", 1'b1, cfgValid_ff);
      chk("run", vec[k][4], wdRunAfterReset_ff);
      checkAll(vec[k]);
    end
    // interrupt raised, masked, unmasked and cleared
    rd(8'h04);
    chk("maskrst", 32'h0, rdData);
    wr(8'h04, 32'h1);
    chk("irqon", 1'b1, irqOut);
    wr(8'h04, 32'h0);
    chk("irqmask", 1'b0, irqOut);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h3);
    chk("irqclr", 1'b0, irqOut);
    wr(8'h08, 32'hFF);
    rd(8'h08);
    chk("readonly", vec[7][7:0], rdData);
    wr(8'h20, 32'h1);
    chk("badwr", 2'h2, rsp);
    rd(8'h1C);
    chk("badrd", 32'h0, rdData);
    chk("badrsp", 32'h2, rsp);
    summarize();
  end
endmodule // tb_option_byte_config_decoder
